/* include/ffm_pkg.sv */
/*
  Package for the fail-safe fault manager: register offsets, field positions,
  reset values and timing constants.
  Assumes a 125 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package ffm_pkg;
  // ---------------------------------------------------------------------
  // channels and clock
  // ---------------------------------------------------------------------
  localparam int NUM_CH          = 12;
  localparam int CLK_MHZ         = 125;
  localparam int RETRY_MS        = 10;
  localparam int RETRY_CYCLES    = RETRY_MS * 1000 * CLK_MHZ;
  localparam int DEGLITCH_OPEN   = 16;  // open deglitch, cycles
  localparam int DEGLITCH_SHORT  = 16;  // short deglitch, cycles

  // ---------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CHEN    = 8'h04;
  localparam logic [7:0] OFF_DIAGEN  = 8'h08;
  localparam logic [7:0] OFF_DIAGCFG = 8'h0C;
  localparam logic [7:0] OFF_FLAGS   = 8'h10;
  localparam logic [7:0] OFF_OPEN    = 8'h14;
  localparam logic [7:0] OFF_SHORT   = 8'h18;
  localparam logic [7:0] OFF_ADC     = 8'h1C;
  localparam logic [7:0] OFF_OUTEN   = 8'h20;

  // ---------------------------------------------------------------------
  // control and diagnostic config register fields
  // ---------------------------------------------------------------------
  localparam int CTRL_CLEAR     = 0;
  localparam int CTRL_ALLFAIL   = 1;
  localparam int CTRL_MASK_REF  = 2;
  localparam int CTRL_MASK_OPEN = 3;
  localparam int CTRL_MASK_SHRT = 4;
  localparam int CTRL_MASK_TSD  = 5;
  localparam int CTRL_MASK_CRC  = 6;
  localparam int CTRL_LOWSUP_LO = 8;   // 8-bit low-supply threshold
  localparam int DCFG_PW_LO     = 0;   // 8-bit diag pulse width, cycles
  localparam int DCFG_IOUT_LO   = 8;   // 6-bit retry current

  // ---------------------------------------------------------------------
  // flags register fields
  // ---------------------------------------------------------------------
  localparam int FLG_ERR     = 0;
  localparam int FLG_OUT     = 1;
  localparam int FLG_POR     = 2;
  localparam int FLG_LOWSUP  = 3;
  localparam int FLG_REF     = 4;
  localparam int FLG_TSD     = 5;
  localparam int FLG_CRC     = 6;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_DIAGCFG = 32'h0000_0008;
endpackage : ffm_pkg

/* rtl/ffm_retry_timer.sv */
/*
  Shared retry interval timer: one counter, held at zero while run is low, that pulses once per interval.
  Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ffm_retry_timer #(
  parameter int PERIOD = ffm_pkg::RETRY_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // control
  input  wire logic run,
  // tick out
  output logic      tick
);
  logic [31:0] count;

  // count while any channel waits for retry, tick at the end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == 32'(PERIOD - 1)) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule : ffm_retry_timer

/* rtl/ffm_fault_manager.sv */
/*
  Fail-safe fault manager: channel shutdown, masking, flags, retry and the
  open-drain fault report pin, with a classic Wishbone register slave.
  Assumes analog comparators arrive as synchronous levels, and the ADC hands
  over one supply code with a one-cycle strobe per conversion.
*/
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ffm_fault_manager #(
  parameter int NCH          = ffm_pkg::NUM_CH,
  parameter int RETRY_PERIOD = ffm_pkg::RETRY_CYCLES
) (
  // clock and reset (reset also driven by undervoltage and thermal restart)
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // device state and analog sense
  input  wire logic             failsafe,
  input  wire logic [NCH-1:0]   pwm_on,
  input  wire logic [NCH-1:0]   open_cmp,
  input  wire logic [NCH-1:0]   short_cmp,
  input  wire logic             bias_fault,
  input  wire logic             thermal_fault,
  input  wire logic             checksum_fault,
  input  wire logic [7:0]       adc_supply,
  input  wire logic             adc_done,
  // channel drive
  output logic      [NCH-1:0]   channel_on,
  output logic      [NCH-1:0]   retry_pulse,
  output logic      [5:0]       retry_current,
  // fault report pin, open drain
  output logic                  fault_pin_o,
  output logic                  fault_pin_oe
);
  // -----------------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------------
  logic [31:0]    ctrl;
  logic [NCH-1:0] channel_enable_bit;
  logic [NCH-1:0] channel_diag_enable;
  logic [7:0]     diag_pulse_width;
  logic [5:0]     retry_current_setting;
  logic [NCH-1:0] channel_open_flag;
  logic [NCH-1:0] channel_short_flag;
  logic [NCH-1:0] failed;
  logic           low_supply_flag, bias_flag, thermal_flag, crc_flag, por_flag;
  logic           err_flag, out_flag;
  logic [7:0]     supply_result;
  logic [8:0]     run_cnt [NCH];
  logic           tick;
  logic           clr_req;
  logic [NCH-1:0] in_retry;

  wire logic       all_fail_select    = ctrl[ffm_pkg::CTRL_ALLFAIL];
  wire logic       bias_fault_mask    = ctrl[ffm_pkg::CTRL_MASK_REF];
  wire logic       open_fault_mask    = ctrl[ffm_pkg::CTRL_MASK_OPEN];
  wire logic       short_fault_mask   = ctrl[ffm_pkg::CTRL_MASK_SHRT];
  wire logic       thermal_fault_mask = ctrl[ffm_pkg::CTRL_MASK_TSD];
  wire logic       checksum_fault_mask = ctrl[ffm_pkg::CTRL_MASK_CRC];
  wire logic [7:0] low_supply_threshold = ctrl[ffm_pkg::CTRL_LOWSUP_LO +: 8];

  // -----------------------------------------------------------------------
  // wishbone slave, one-cycle ack
  // -----------------------------------------------------------------------
  wire logic wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr    = wb_req && wb_we_i;
  function automatic logic wr_hit(input logic [7:0] off, input logic [7:0] adr);
    wr_hit = (adr == off);
  endfunction : wr_hit

  // ack one cycle after request, dropped next cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) wb_ack_o <= 1'b0;
    else       wb_ack_o <= wb_req;
  end

  // configuration writes; clear bit self-returns to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl                  <= ffm_pkg::RST_CTRL;
      channel_enable_bit    <= '0;
      channel_diag_enable   <= '0;
      diag_pulse_width      <= ffm_pkg::RST_DIAGCFG[7:0];
      retry_current_setting <= 6'h00;
    end else begin
      ctrl[ffm_pkg::CTRL_CLEAR] <= 1'b0;
      if (wb_wr && wr_hit(ffm_pkg::OFF_CTRL, wb_adr_i)) begin
        if (wb_sel_i[0]) ctrl[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) ctrl[15:8] <= wb_dat_i[15:8];
      end
      if (wb_wr && wr_hit(ffm_pkg::OFF_CHEN, wb_adr_i))
        channel_enable_bit <= wb_dat_i[NCH-1:0];
      if (wb_wr && wr_hit(ffm_pkg::OFF_DIAGEN, wb_adr_i))
        channel_diag_enable <= wb_dat_i[NCH-1:0];
      if (wb_wr && wr_hit(ffm_pkg::OFF_DIAGCFG, wb_adr_i)) begin
        if (wb_sel_i[0]) diag_pulse_width      <= wb_dat_i[7:0];
        if (wb_sel_i[1]) retry_current_setting <= wb_dat_i[13:8];
      end
    end
  end

  // clear strobe seen by flag logic on the write itself
  assign clr_req = wb_wr && wr_hit(ffm_pkg::OFF_CTRL, wb_adr_i) && wb_sel_i[0]
                   && wb_dat_i[ffm_pkg::CTRL_CLEAR];

  // read mux; flags stay readable in every state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ffm_pkg::OFF_CTRL:    wb_dat_o <= ctrl;
        ffm_pkg::OFF_CHEN:    wb_dat_o <= 32'(channel_enable_bit);
        ffm_pkg::OFF_DIAGEN:  wb_dat_o <= 32'(channel_diag_enable);
        ffm_pkg::OFF_DIAGCFG: wb_dat_o <= {18'h0, retry_current_setting, diag_pulse_width};
        ffm_pkg::OFF_FLAGS:   wb_dat_o <= {25'h0, crc_flag, thermal_flag, bias_flag,
                                           low_supply_flag, por_flag, out_flag, err_flag};
        ffm_pkg::OFF_OPEN:    wb_dat_o <= 32'(channel_open_flag);
        ffm_pkg::OFF_SHORT:   wb_dat_o <= 32'(channel_short_flag);
        ffm_pkg::OFF_ADC:     wb_dat_o <= {24'h0, supply_result};
        ffm_pkg::OFF_OUTEN:   wb_dat_o <= 32'(channel_on);
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // supply monitor
  // -----------------------------------------------------------------------
  wire logic supply_low = supply_result < low_supply_threshold;

  // latest conversion result
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) supply_result <= 8'hFF;
    else if (adc_done) supply_result <= adc_supply;
  end

  // -----------------------------------------------------------------------
  // per-channel on-time qualification
  // -----------------------------------------------------------------------
  logic [NCH-1:0] diag_ok, open_det, short_det;
  wire logic [8:0] open_need  = {1'b0, diag_pulse_width} + 9'(ffm_pkg::DEGLITCH_OPEN);
  wire logic [8:0] short_need = {1'b0, diag_pulse_width} + 9'(ffm_pkg::DEGLITCH_SHORT);

  // channels that are diagnosed at all
  assign diag_ok = channel_enable_bit & channel_diag_enable;

  // count cycles of on-time with the fault condition present
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) run_cnt[i] <= 9'h000;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (pwm_on[i] && (open_cmp[i] || short_cmp[i]) && run_cnt[i] != 9'h1FF)
          run_cnt[i] <= run_cnt[i] + 9'h001;
        else if (!(pwm_on[i] && (open_cmp[i] || short_cmp[i])))
          run_cnt[i] <= 9'h000;
      end
    end
  end

  // detection only while driven; open also needs a healthy supply
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      open_det[i]  = diag_ok[i] && pwm_on[i] && open_cmp[i] && !supply_low
                     && run_cnt[i] >= open_need;
      short_det[i] = diag_ok[i] && pwm_on[i] && short_cmp[i]
                     && run_cnt[i] >= short_need;
    end
  end

  // -----------------------------------------------------------------------
  // retry of failed channels
  // -----------------------------------------------------------------------
  ffm_retry_timer #(
    .PERIOD (RETRY_PERIOD)
  ) u_retry (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (|in_retry),
    .tick    (tick)
  );

  assign in_retry = failed & {NCH{failsafe}};

  logic [7:0] pulse_cnt;
  logic       pulse_active;

  // low-current pulse on every failed channel in fail-safe state once per interval
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt    <= 8'h00;
      pulse_active <= 1'b0;
      retry_pulse  <= '0;
    end else if (tick) begin
      pulse_cnt    <= diag_pulse_width;
      pulse_active <= 1'b1;
      retry_pulse  <= in_retry;
    end else if (pulse_active && pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end else begin
      pulse_active <= 1'b0;
      retry_pulse  <= '0;
    end
  end

  // retry current follows its setting
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) retry_current <= 6'h00;
    else       retry_current <= retry_current_setting;
  end

  // a pulse that ends with both comparators quiet restores the channel
  wire logic [NCH-1:0] recovered = retry_pulse & ~open_cmp & ~short_cmp
                                   & {NCH{pulse_cnt == 8'h00}};

  // failed state per channel; a pulse without fault restores it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) failed <= '0;
    else begin
      for (int i = 0; i < NCH; i++) begin
        if (open_det[i] || short_det[i])
          failed[i] <= 1'b1;
        else if (recovered[i])
          failed[i] <= 1'b0;
        else if (!diag_ok[i])
          failed[i] <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // fault flags; hardware set wins over software clear
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      channel_open_flag  <= '0;
      channel_short_flag <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (open_det[i]) channel_open_flag[i] <= 1'b1;
        else if (clr_req || recovered[i] || !diag_ok[i]) channel_open_flag[i] <= 1'b0;
        if (short_det[i]) channel_short_flag[i] <= 1'b1;
        else if (clr_req || recovered[i] || !diag_ok[i]) channel_short_flag[i] <= 1'b0;
      end
    end
  end

  // global flags; power-on flag comes up set after any reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      por_flag        <= 1'b1;
      low_supply_flag <= 1'b0;
      bias_flag       <= 1'b0;
      thermal_flag    <= 1'b0;
      crc_flag        <= 1'b0;
    end else begin
      if (clr_req) por_flag <= 1'b0;
      if (supply_low) low_supply_flag <= 1'b1;
      else if (clr_req || failsafe) low_supply_flag <= 1'b0;
      if (bias_fault) bias_flag <= 1'b1;
      else if (clr_req) bias_flag <= 1'b0;
      if (thermal_fault) thermal_flag <= 1'b1;
      else if (clr_req) thermal_flag <= 1'b0;
      if (checksum_fault) crc_flag <= 1'b1;
      else if (clr_req) crc_flag <= 1'b0;
    end
  end

  // masked summaries for the output and error flags and the pin
  wire logic open_rep  = |channel_open_flag  && !open_fault_mask;
  wire logic short_rep = |channel_short_flag && !short_fault_mask;
  wire logic next_out  = open_rep || short_rep;
  wire logic next_err  = next_out || por_flag || low_supply_flag
                         || (bias_flag && !bias_fault_mask)
                         || (thermal_flag && !thermal_fault_mask)
                         || (crc_flag && !checksum_fault_mask);
  wire logic next_pin  = (|(failed & diag_ok) && next_out)
                         || (bias_fault && !bias_fault_mask)
                         || (thermal_fault && !thermal_fault_mask)
                         || (checksum_fault && !checksum_fault_mask);

  // registered summary flags and open-drain pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_flag     <= 1'b0;
      err_flag     <= 1'b1;
      fault_pin_oe <= 1'b1;
      fault_pin_o  <= 1'b0;
    end else begin
      out_flag     <= next_out;
      err_flag     <= next_err;
      fault_pin_oe <= next_pin;
      fault_pin_o  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // channel drive
  // -----------------------------------------------------------------------
  wire logic all_off = thermal_fault || (failsafe && (bias_fault || checksum_fault))
                       || (failsafe && all_fail_select && |failed);

  // enabled channels run unless failed or globally shut down
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) channel_on <= '0;
    else if (all_off) channel_on <= '0;
    else channel_on <= channel_enable_bit & ~failed;
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  a_clear_self: assert property (@(posedge ref_clk) disable iff (!nrst)
    clr_req |=> ctrl[ffm_pkg::CTRL_CLEAR] ##1 !ctrl[ffm_pkg::CTRL_CLEAR])
    else $error("clear bit stuck");
  a_thermal_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    thermal_fault |=> channel_on == '0) else $error("outputs on in overtemp");
  a_allfail_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    failsafe && all_fail_select && |failed |=> channel_on == '0)
    else $error("all-fail not applied");
  a_bias_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
    bias_fault && !bias_fault_mask |=> fault_pin_oe) else $error("pin not low");
  a_mask_open: assert property (@(posedge ref_clk) disable iff (!nrst)
    open_fault_mask && channel_short_flag == '0 |=> !out_flag)
    else $error("masked out");
  a_adc_update: assert property (@(posedge ref_clk) disable iff (!nrst)
    adc_done |=> supply_result == $past(adc_supply)) else $error("adc stale");
  a_lowsup_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    supply_low |=> low_supply_flag ##1 err_flag) else $error("lowsup flag");
  a_nodiag_open: assert property (@(posedge ref_clk) disable iff (!nrst)
    !diag_ok[0] |=> !channel_open_flag[0]) else $error("diag off yet flag");
  a_wb_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
    wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  c_retry: cover property (@(posedge ref_clk) disable iff (!nrst) tick && |in_retry);
  c_open: cover property (@(posedge ref_clk) disable iff (!nrst) |open_det);
  c_recover: cover property (@(posedge ref_clk) disable iff (!nrst) |recovered);
endmodule : ffm_fault_manager

/* tb/ffm_master_model.sv */
/*
  Master controller model: issues classic Wishbone cycles for the bench.
  Assumes the slave answers with a one-cycle registered ack.
*/
`timescale 1ns/1ps
module ffm_master_model (
  // clock
  input  wire logic        ref_clk,
  // wishbone master side
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  // idle bus at time zero
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0000_0000;
  end

  // one cycle, held until ack is sampled; read data returned in rd
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, we};
    wb_adr_o <= adr;
    wb_dat_o <= wd;
    do @(posedge ref_clk); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
    wb_dat_o <= ~wd;  // released data no longer shows the word
  endtask : xfer
endmodule : ffm_master_model

/* tb/failsafe_fault_manager_tb.sv */
/*
  Self-checking bench for the fault manager, one task per scenario.
  Assumes the master model drives the register bus.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, m); end end
module failsafe_fault_manager_tb;
  logic        ref_clk, nrst, failsafe, adc_done, cyc, stb, we, ack, oe, pin_o, seen0;
  logic [11:0] pwm_on, open_cmp, short_cmp, chon, rpulse;
  logic [7:0]  adc_supply, adr;
  logic [3:0]  sel;
  logic [2:0]  gf;
  logic [5:0]  rcur;
  logic [31:0] wdat, rdat, rd_v, ctrl_v;
  int          err_total, tests_run;
  localparam logic [31:0] F_ERR = 32'h1 << ffm_pkg::FLG_ERR;
  localparam logic [31:0] F_OUT = 32'h1 << ffm_pkg::FLG_OUT;
  localparam logic [31:0] F_POR = 32'h1 << ffm_pkg::FLG_POR;
  localparam logic [31:0] F_LOW = 32'h1 << ffm_pkg::FLG_LOWSUP;
  int          gflag [3] = '{ffm_pkg::FLG_REF, ffm_pkg::FLG_TSD, ffm_pkg::FLG_CRC};
  int          gmask [3] = '{ffm_pkg::CTRL_MASK_REF, ffm_pkg::CTRL_MASK_TSD,
                             ffm_pkg::CTRL_MASK_CRC};

  // ---------------------------------------------------------------------
  // design, master model, clock
  // ---------------------------------------------------------------------
  ffm_fault_manager #(.RETRY_PERIOD(50)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .failsafe(failsafe), .pwm_on(pwm_on), .open_cmp(open_cmp), .short_cmp(short_cmp),
    .bias_fault(gf[0]), .thermal_fault(gf[1]), .checksum_fault(gf[2]),
    .adc_supply(adc_supply), .adc_done(adc_done), .channel_on(chon),
    .retry_pulse(rpulse), .retry_current(rcur), .fault_pin_o(pin_o), .fault_pin_oe(oe));
  ffm_master_model m (
    .ref_clk(ref_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // remember a retry pulse on channel 0
  always @(posedge ref_clk) if (rpulse[0] === 1'b1) seen0 <= 1'b1;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic step(input int n); repeat (n) @(posedge ref_clk); endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd_v);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
    m.xfer(1'b0, a, 32'h0000_0000, rd_v);
    `CHK(rd_v, e, s)
  endtask : rdchk
  task automatic wait_on(input logic [11:0] e);
    int n;
    n = 0;
    while (chon !== e && n < 400) begin @(posedge ref_clk); n++; end
    `CHK(chon, e, "channels not restored")
  endtask : wait_on
  task automatic adc(input logic [7:0] v);
    @(posedge ref_clk);
    adc_supply <= v;
    adc_done <= 1'b1;
    @(posedge ref_clk);
    adc_done <= 1'b0;
    step(3);
  endtask : adc

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    `CHK(oe, 1'b1, "pin after reset")
    rdchk(ffm_pkg::OFF_FLAGS, F_ERR | F_POR, "power-on flags");
    rdchk(ffm_pkg::OFF_CTRL, ffm_pkg::RST_CTRL, "ctrl reset");
    rdchk(ffm_pkg::OFF_DIAGCFG, ffm_pkg::RST_DIAGCFG, "diagcfg reset");
    rdchk(ffm_pkg::OFF_ADC, 32'h0000_00FF, "supply reset");
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0000_0000, "unmapped");
    wr(ffm_pkg::OFF_CHEN, 32'hFFF);
    wr(ffm_pkg::OFF_DIAGEN, 32'hFFF);
    wr(ffm_pkg::OFF_DIAGCFG, 32'h0000_2A08);
    wr(ffm_pkg::OFF_CTRL, ctrl_v | 32'h1);
    rdchk(ffm_pkg::OFF_CTRL, ctrl_v, "clear bit stays set");
    rdchk(ffm_pkg::OFF_FLAGS, 32'h0, "flags not cleared");
    `CHK(oe, 1'b0, "pin not released")
    `CHK(rcur, 6'h2A, "retry current")
  endtask : t_reset

  task automatic t_lowsup;
    adc(8'h20);
    rdchk(ffm_pkg::OFF_ADC, 32'h20, "supply result");
    rdchk(ffm_pkg::OFF_FLAGS, F_ERR | F_LOW, "low supply flags");
    `CHK(oe, 1'b0, "low supply drove pin")
    adc(8'hC0);
    rdchk(ffm_pkg::OFF_FLAGS, 32'h0, "low supply flags kept");
  endtask : t_lowsup

  task automatic t_short_retry;
    seen0 <= 1'b0;
    short_cmp <= 12'h001;
    step(40);
    `CHK(chon, 12'hFFE, "short channel off")
    rdchk(ffm_pkg::OFF_SHORT, 32'h1, "short flag");
    rdchk(ffm_pkg::OFF_FLAGS, F_ERR | F_OUT, "short summary");
    `CHK(oe, 1'b1, "short pin")
    short_cmp <= 12'h000;
    wait_on(12'hFFF);
    step(2);
    `CHK(seen0, 1'b1, "no retry pulse")
    rdchk(ffm_pkg::OFF_SHORT, 32'h0, "short flag kept");
    `CHK(oe, 1'b0, "pin after retry")
  endtask : t_short_retry

  task automatic t_allfail;
    wr(ffm_pkg::OFF_CTRL, ctrl_v | (32'h1 << ffm_pkg::CTRL_ALLFAIL));
    open_cmp <= 12'h002;
    step(40);
    `CHK(chon, 12'h000, "all fail")
    rdchk(ffm_pkg::OFF_OPEN, 32'h2, "open flag");
    open_cmp <= 12'h000;
    wait_on(12'hFFF);
  endtask : t_allfail

  task automatic t_masks;
    for (int k = 0; k < 2; k++) begin
      wr(ffm_pkg::OFF_CTRL, ctrl_v | (32'h1 << (ffm_pkg::CTRL_MASK_OPEN + k)));
      if (k == 0) open_cmp <= 12'h004;
      else short_cmp <= 12'h004;
      step(40);
      rdchk(ffm_pkg::OFF_OPEN + 8'(4 * k), 32'h4, "masked detect");
      rdchk(ffm_pkg::OFF_FLAGS, 32'h0, "mask leaked");
      `CHK(oe, 1'b0, "masked pin")
      {open_cmp, short_cmp} <= 24'h0;
      wait_on(12'hFFF);
    end
    wr(ffm_pkg::OFF_CTRL, ctrl_v);
  endtask : t_masks

  task automatic t_disabled;
    wr(ffm_pkg::OFF_CHEN, 32'hFEF);
    wr(ffm_pkg::OFF_DIAGEN, 32'hFF7);
    short_cmp <= 12'h008;
    open_cmp <= 12'h010;
    step(40);
    rdchk(ffm_pkg::OFF_SHORT, 32'h0, "diag off detected");
    rdchk(ffm_pkg::OFF_OPEN, 32'h0, "disabled detected");
    `CHK(chon, 12'hFEF, "disabled channels")
    `CHK(oe, 1'b0, "disabled pin")
    {open_cmp, short_cmp} <= 24'h0;
    wr(ffm_pkg::OFF_CHEN, 32'hFFF);
    wr(ffm_pkg::OFF_DIAGEN, 32'hFFF);
  endtask : t_disabled

  task automatic t_pulse;
    for (int k = 0; k < 3; k++) begin
      pwm_on <= 12'hFDF;
      step(8);
      {pwm_on, open_cmp} <= {12'hFFF, 12'h020};
      step(20);
    end
    {pwm_on, open_cmp} <= {12'hFFF, 12'h000};
    rdchk(ffm_pkg::OFF_OPEN, 32'h0, "short pulse detected");
    `CHK(chon, 12'hFFF, "short pulse channel off")
  endtask : t_pulse

  task automatic t_global;
    for (int k = 0; k < 3; k++) begin
      gf <= 3'(1 << k);
      step(4);
      `CHK(chon, 12'h000, "global off")
      rdchk(ffm_pkg::OFF_FLAGS, F_ERR | (32'h1 << gflag[k]), "global flag");
      `CHK(oe, 1'b1, "global pin")
      gf <= 3'h0;
      step(4);
      `CHK(chon, 12'hFFF, "global recover")
      `CHK(oe, 1'b0, "global release")
      rdchk(ffm_pkg::OFF_FLAGS, F_ERR | (32'h1 << gflag[k]), "flag lost");
      wr(ffm_pkg::OFF_CTRL, ctrl_v | (32'h1 << gmask[k]) | 32'h1);
      gf <= 3'(1 << k);
      step(4);
      rdchk(ffm_pkg::OFF_FLAGS, 32'h1 << gflag[k], "masked error");
      `CHK(oe, 1'b0, "masked global pin")
      gf <= 3'h0;
      step(4);
      wr(ffm_pkg::OFF_CTRL, ctrl_v | 32'h1);
    end
  endtask : t_global

  // ---------------------------------------------------------------------
  // sequence, watchdog, verdict
  // ---------------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // reset, then every scenario in fail-safe state
  initial begin
    {nrst, adc_done, seen0, gf, open_cmp, short_cmp} = 0;
    {failsafe, pwm_on, adc_supply} = {1'b1, 12'hFFF, 8'hC0};
    ctrl_v = 32'h0000_4000;
    err_total = 0;
    tests_run = 0;
    step(2);
    nrst <= 1'b1;
    t_reset();
    t_lowsup();
    t_short_retry();
    t_allfail();
    t_masks();
    t_disabled();
    t_pulse();
    t_global();
    summarize();
  end
  // hang guard, far beyond the expected run
  initial begin
    step(20000);
    err_total++;
    summarize();
  end
endmodule : failsafe_fault_manager_tb
